// ---- cdid_decoder.sv ----
// instruction decoder for a character display controller with a host byte port
// assumes the host port is driven from logic on core_clk; one strobe at a time

`timescale 1ns/1ps
`default_nettype none

module cdid_decoder #(
	parameter int CLEAR_CYCLES = cdid_pkg::CLEAR_CYCLES
) (
	input  wire logic       core_clk,          // core clock
	input  wire logic       rst_n,             // async reset, low
	input  wire logic [1:0] host_addr,         // bit 0 is reg_select_line
	input  wire logic [7:0] host_wdata,        // write byte
	input  wire logic       host_wr,           // write strobe
	input  wire logic       host_rd,           // read strobe
	output logic      [7:0] host_rdata,        // read byte, cycle after strobe
	output logic            irq,               // level interrupt
	output logic            busy_flag,         // command executing
	output logic      [6:0] address_counter,   // current counter
	output logic      [6:0] shift_offset,      // display shift position
	output logic            display_on,        // display enable
	output logic            cursor_on,         // cursor visible
	output logic            blink_on,          // cursor char blinking
	output logic            graphic_mode,      // 1 graphic, 0 character
	output logic            power_on,          // internal power enable
	output logic            bus_width_select,  // interface width
	output logic            line_count,        // display lines
	output logic            glyph_size,        // font size
	output logic      [1:0] font_table_select  // font table
);
	typedef struct packed {
		cdid_pkg::cdid_state_t     st;
		logic                      busy;
		logic [cdid_pkg::CNT_W-1:0] cnt;
		logic [6:0]                ac;
		logic                      sel_glyph;
		logic                      step_pend;
		logic                      inc;
		logic                      shift_en;
		logic [6:0]                shift;
		logic                      disp;
		logic                      cur;
		logic                      blink;
		logic                      gmode;
		logic                      pwr;
		logic                      dl;
		logic                      lines;
		logic                      fsize;
		logic [1:0]                ft;
		logic [7:0]                rdata;
		logic [cdid_pkg::IRQ_W-1:0] stat;
		logic [cdid_pkg::IRQ_W-1:0] ien;
		logic                      irq;
		logic [7:0]                clr_idx;
	} cdid_state_t;

	cdid_state_t r_reg;
	cdid_state_t r_next;

	logic       disp_we;
	logic [6:0] disp_waddr;
	logic [7:0] disp_wdata;
	logic       glyph_we;
	logic [7:0] disp_rd;
	logic [7:0] glyph_rd;

	function automatic cdid_pkg::cdid_cmd_t cdid_decode(input logic [7:0] b);
		cdid_pkg::cdid_cmd_t c;
		c = cdid_pkg::CDID_CMD_NONE;
		if (b[7])
			c = cdid_pkg::CDID_CMD_DADDR;
		else if (b[6])
			c = cdid_pkg::CDID_CMD_GLYPH;
		else if (b[5])
			c = cdid_pkg::CDID_CMD_FUNC;
		else if (b[4])
			c = cdid_pkg::CDID_CMD_SHIFT;
		else if (b[3])
			c = cdid_pkg::CDID_CMD_DISP;
		else if (b[2])
			c = cdid_pkg::CDID_CMD_ENTRY;
		else if (b[1])
			c = cdid_pkg::CDID_CMD_HOME;
		else if (b[0])
			c = cdid_pkg::CDID_CMD_CLEAR;
		return c;
	endfunction : cdid_decode

	function automatic logic [6:0] cdid_step(input logic [6:0] v, input logic up);
		return up ? 7'(v + 7'h01) : 7'(v - 7'h01);
	endfunction : cdid_step

	localparam logic [cdid_pkg::CNT_W-1:0] CLR_CNT  = cdid_pkg::CNT_W'(CLEAR_CYCLES);
	localparam logic [cdid_pkg::CNT_W-1:0] EXEC_CNT = cdid_pkg::CNT_W'(cdid_pkg::CMD_EXEC_CYCLES);
	localparam logic [7:0]                 CLR_END  = 8'(cdid_pkg::DISP_DEPTH);

	always_comb begin
		cdid_pkg::cdid_cmd_t       cmd;
		logic [cdid_pkg::IRQ_W-1:0] ev;
		logic                      accept;
		cmd        = cdid_decode(host_wdata);
		ev         = '0;
		accept     = 1'b0;
		r_next     = r_reg;
		disp_we    = 1'b0;
		disp_waddr = r_reg.ac;
		disp_wdata = host_wdata;
		glyph_we   = 1'b0;

		// busy countdown; blanking walk runs first
		unique case (r_reg.st)
			cdid_pkg::CDID_ST_IDLE: begin
			end
			cdid_pkg::CDID_ST_EXEC, cdid_pkg::CDID_ST_CLEAR: begin
				if (r_reg.st == cdid_pkg::CDID_ST_CLEAR && r_reg.clr_idx != CLR_END) begin
					disp_we        = 1'b1;
					disp_waddr     = r_reg.clr_idx[6:0];
					disp_wdata     = cdid_pkg::BLANK_CHAR;
					r_next.clr_idx = 8'(r_reg.clr_idx + 8'h01);
				end
				r_next.cnt = r_reg.cnt - 1'b1;
				if (r_reg.cnt <= 1) begin
					r_next.st   = cdid_pkg::CDID_ST_IDLE;
					r_next.busy = 1'b0;
					ev[cdid_pkg::IRQ_DONE] = 1'b1;
					if (r_reg.st == cdid_pkg::CDID_ST_CLEAR)
						ev[cdid_pkg::IRQ_CLEAR] = 1'b1;
					if (r_reg.step_pend)
						r_next.ac = cdid_step(r_reg.ac, r_reg.inc);
					r_next.step_pend = 1'b0;
				end
			end
			default: begin
				r_next.st   = cdid_pkg::CDID_ST_IDLE;
				r_next.busy = 1'b0;
			end
		endcase

		if (host_rd) begin
			unique case (host_addr)
				cdid_pkg::ADDR_INSTR: r_next.rdata = {r_reg.busy, r_reg.ac};
				cdid_pkg::ADDR_DATA: begin
					r_next.rdata = 8'h00;
					if (r_reg.busy) begin
						ev[cdid_pkg::IRQ_REJECT] = 1'b1;
					end else begin
						if (r_reg.sel_glyph)
							r_next.rdata = glyph_rd;
						else
							r_next.rdata = disp_rd;
						if (r_reg.shift_en)
							r_next.shift = cdid_step(r_reg.shift, r_reg.inc);
						r_next.step_pend = 1'b1;
						accept           = 1'b1;
					end
				end
				cdid_pkg::ADDR_IRQ_STAT: r_next.rdata = 8'(r_reg.stat);
				cdid_pkg::ADDR_IRQ_EN: r_next.rdata = 8'(r_reg.ien);
			endcase
		end

		if (host_wr) begin
			unique case (host_addr)
				cdid_pkg::ADDR_INSTR, cdid_pkg::ADDR_DATA: begin
					if (r_reg.busy) begin
						ev[cdid_pkg::IRQ_REJECT] = 1'b1;
					end else if (host_addr == cdid_pkg::ADDR_DATA) begin
						disp_we          = ~r_reg.sel_glyph;
						glyph_we         = r_reg.sel_glyph;
						if (r_reg.shift_en)
							r_next.shift = cdid_step(r_reg.shift, r_reg.inc);
						r_next.step_pend = 1'b1;
						accept           = 1'b1;
					end else begin
						accept = 1'b1;
						unique case (cmd)
							cdid_pkg::CDID_CMD_NONE: accept = 1'b0;
							cdid_pkg::CDID_CMD_CLEAR: begin
								r_next.ac        = 7'h00;
								r_next.sel_glyph = 1'b0;
								r_next.clr_idx   = 8'h00;
							end
							cdid_pkg::CDID_CMD_HOME: begin
								r_next.ac        = 7'h00;
								r_next.shift     = 7'h00;
								r_next.sel_glyph = 1'b0;
							end
							cdid_pkg::CDID_CMD_ENTRY: begin
								r_next.inc      = host_wdata[cdid_pkg::F_ID];
								r_next.shift_en = host_wdata[cdid_pkg::F_SH];
							end
							cdid_pkg::CDID_CMD_DISP: begin
								r_next.disp  = host_wdata[cdid_pkg::F_DISP];
								r_next.cur   = host_wdata[cdid_pkg::F_CUR];
								r_next.blink = host_wdata[cdid_pkg::F_BLINK];
							end
							cdid_pkg::CDID_CMD_SHIFT: begin
								if (host_wdata[1:0] == 2'h3) begin
									r_next.gmode = host_wdata[cdid_pkg::F_GMODE];
									r_next.pwr   = host_wdata[cdid_pkg::F_PWR];
								end else if (host_wdata[1:0] == 2'h0) begin
									if (host_wdata[cdid_pkg::F_SC])
										r_next.shift = cdid_step(r_reg.shift, host_wdata[cdid_pkg::F_RL]);
									else
										r_next.ac = cdid_step(r_reg.ac, host_wdata[cdid_pkg::F_RL]);
								end
							end
							cdid_pkg::CDID_CMD_FUNC: begin
								r_next.dl    = host_wdata[cdid_pkg::F_DL];
								r_next.lines = host_wdata[cdid_pkg::F_LINES];
								r_next.fsize = host_wdata[cdid_pkg::F_FSIZE];
								r_next.ft    = host_wdata[1:0];
							end
							cdid_pkg::CDID_CMD_GLYPH: begin
								r_next.ac        = {1'b0, host_wdata[5:0]};
								r_next.sel_glyph = 1'b1;
							end
							cdid_pkg::CDID_CMD_DADDR: begin
								r_next.ac        = host_wdata[6:0];
								r_next.sel_glyph = 1'b0;
							end
							default: accept = 1'b0;
						endcase
					end
				end
				cdid_pkg::ADDR_IRQ_STAT: r_next.stat = r_reg.stat & ~host_wdata[cdid_pkg::IRQ_W-1:0];
				cdid_pkg::ADDR_IRQ_EN: r_next.ien = host_wdata[cdid_pkg::IRQ_W-1:0];
			endcase
		end

		if (accept) begin
			r_next.busy = 1'b1;
			if (host_wr && host_addr == cdid_pkg::ADDR_INSTR && cmd == cdid_pkg::CDID_CMD_CLEAR) begin
				r_next.st  = cdid_pkg::CDID_ST_CLEAR;
				r_next.cnt = CLR_CNT;
			end else begin
				r_next.st  = cdid_pkg::CDID_ST_EXEC;
				r_next.cnt = EXEC_CNT;
			end
		end

		// set wins over clear
		r_next.stat = r_next.stat | ev;
		r_next.irq  = |(r_next.stat & r_next.ien);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg       <= '0;
			r_reg.st    <= cdid_pkg::CDID_ST_IDLE;
			r_reg.inc   <= cdid_pkg::RST_ID;
			r_reg.dl    <= cdid_pkg::RST_DL;
			r_reg.ft    <= cdid_pkg::RST_FT;
			r_reg.ien   <= cdid_pkg::RST_IRQ_EN;
			r_reg.clr_idx <= CLR_END;
		end else begin
			r_reg <= r_next;
		end
	end

	cdid_ram #(
		.DEPTH (cdid_pkg::DISP_DEPTH),
		.AW    (cdid_pkg::AC_W)
	) u_display_char_ram (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (disp_we),
		.wr_addr  (disp_waddr),
		.wr_data  (disp_wdata),
		.rd_addr  (r_reg.ac),
		.rd_data  (disp_rd)
	);

	cdid_ram #(
		.DEPTH (cdid_pkg::GLYPH_DEPTH),
		.AW    (cdid_pkg::GLYPH_AW)
	) u_glyph_pattern_ram (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (glyph_we),
		.wr_addr  (r_reg.ac[5:0]),
		.wr_data  (host_wdata),
		.rd_addr  (r_reg.ac[5:0]),
		.rd_data  (glyph_rd)
	);

	assign host_rdata        = r_reg.rdata;
	assign irq               = r_reg.irq;
	assign busy_flag         = r_reg.busy;
	assign address_counter   = r_reg.ac;
	assign shift_offset      = r_reg.shift;
	assign display_on        = r_reg.disp;
	assign cursor_on         = r_reg.cur;
	assign blink_on          = r_reg.blink;
	assign graphic_mode      = r_reg.gmode;
	assign power_on          = r_reg.pwr;
	assign bus_width_select  = r_reg.dl;
	assign line_count        = r_reg.lines;
	assign glyph_size        = r_reg.fsize;
	assign font_table_select = r_reg.ft;
endmodule : cdid_decoder

`default_nettype wire

// ---- cdid_decoder_sva.sv ----
// checker for the instruction decoder host port
// assumes it is bound into cdid_decoder and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cdid_decoder_sva #(
	parameter int CLEAR_CYCLES = cdid_pkg::CLEAR_CYCLES
) (
	input wire logic       core_clk,          // core clock
	input wire logic       rst_n,             // async reset, low
	input wire logic [1:0] host_addr,         // port address
	input wire logic [7:0] host_wdata,        // write byte
	input wire logic       host_wr,           // write strobe
	input wire logic       host_rd,           // read strobe
	input wire logic [7:0] host_rdata,        // read byte
	input wire logic       busy_flag,         // command executing
	input wire logic [6:0] address_counter,   // current counter
	input wire logic [6:0] shift_offset,      // display shift
	input wire logic       display_on,        // display enable
	input wire logic       cursor_on,         // cursor visible
	input wire logic       blink_on,          // blinking
	input wire logic       graphic_mode,      // graphic select
	input wire logic       power_on,          // power enable
	input wire logic       bus_width_select,  // interface width
	input wire logic       line_count,        // display lines
	input wire logic       glyph_size,        // font size
	input wire logic [1:0] font_table_select  // font table
);
	logic ins;
	logic clr_seen;
	int   busy_cnt;
	assign ins = host_wr && host_addr == cdid_pkg::ADDR_INSTR && !busy_flag;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// busy length since an accepted clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 0;
			clr_seen <= 1'b0;
		end else begin
			busy_cnt <= busy_flag ? busy_cnt + 1 : 0;
			clr_seen <= (ins && host_wdata == 8'h01) ? 1'b1 : (busy_flag ? clr_seen : 1'b0);
		end
	end
	clear_start_a: assert property (ins && host_wdata == 8'h01 |=> busy_flag && address_counter == 7'h00)
		else $error("clear did not start busy with counter zero");
	clear_len_a: assert property ($fell(busy_flag) && clr_seen |-> busy_cnt == CLEAR_CYCLES)
		else $error("clear busy length wrong");
	home_zero_a: assert property (ins && host_wdata[7:1] == 7'h01 |=> address_counter == 7'h00 && shift_offset == 7'h00)
		else $error("return home left counter or shift");
	disp_ctl_a: assert property (ins && host_wdata[7:3] == 5'h01 |=> {display_on, cursor_on, blink_on} == $past(host_wdata[2:0]))
		else $error("display control flags wrong");
	mode_pwr_a: assert property (ins && host_wdata[7:4] == 4'h1 && host_wdata[1:0] == 2'h3
		|=> {graphic_mode, power_on} == $past(host_wdata[3:2]))
		else $error("mode or power flag wrong");
	func_set_a: assert property (ins && host_wdata[7:5] == 3'h1
		|=> {bus_width_select, line_count, glyph_size, font_table_select} == $past(host_wdata[4:0]))
		else $error("function set fields wrong");
	daddr_load_a: assert property (ins && host_wdata[7] |=> address_counter == $past(host_wdata[6:0]))
		else $error("display address not loaded");
	status_read_a: assert property (host_rd && host_addr == cdid_pkg::ADDR_INSTR
		|=> host_rdata == {$past(busy_flag), $past(address_counter)})
		else $error("status read wrong");
	short_busy_a: assert property (!busy_flag && ((ins && host_wdata > 8'h01) ||
		(host_addr == cdid_pkg::ADDR_DATA && (host_wr || host_rd))) |=> busy_flag [*2] ##1 !busy_flag)
		else $error("short command busy length wrong");
	busy_drop_a: assert property (busy_flag && host_wr && host_addr == cdid_pkg::ADDR_INSTR
		|=> $stable(display_on) && $stable(graphic_mode) && $stable(font_table_select))
		else $error("command taken while busy");
	busy_read_a: assert property (busy_flag && host_rd && host_addr == cdid_pkg::ADDR_DATA |=> host_rdata == 8'h00)
		else $error("data read honoured while busy");
endmodule : cdid_decoder_sva
bind cdid_decoder cdid_decoder_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (
	.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr), .host_wdata(host_wdata),
	.host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .busy_flag(busy_flag),
	.address_counter(address_counter), .shift_offset(shift_offset), .display_on(display_on),
	.cursor_on(cursor_on), .blink_on(blink_on), .graphic_mode(graphic_mode), .power_on(power_on),
	.bus_width_select(bus_width_select), .line_count(line_count), .glyph_size(glyph_size),
	.font_table_select(font_table_select));
`default_nettype wire

// ---- cdid_host.sv ----
// host processor model: byte port writes, reads and busy polling
// assumes core_clk from the bench; one strobe at a time
`timescale 1ns/1ps
`default_nettype none
module cdid_host (
	input  wire logic       core_clk,    // core clock
	input  wire logic [7:0] host_rdata,  // read byte
	output var  logic [1:0] host_addr,   // port address
	output var  logic [7:0] host_wdata,  // write byte
	output var  logic       host_wr,     // write strobe
	output var  logic       host_rd      // read strobe
);
	initial begin
		host_addr = 2'h0;
		host_wdata = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == cdid_pkg::ADDR_INSTR && d[7:1] == 7'h01) v[0] = 1'b0;
		@(posedge core_clk);
		host_addr <= a;
		host_wdata <= v;
		host_wr <= 1'b1;
		@(posedge core_clk);
		host_wr <= 1'b0;
		host_addr <= ~a;
		host_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge core_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge core_clk);
		host_rd <= 1'b0;
		host_addr <= ~a;
		#1 d = host_rdata;
	endtask : rd
	task automatic wait_idle(output logic ok);
		logic [7:0] s;
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			rd(cdid_pkg::ADDR_INSTR, s);
			ok = (s[7] === 1'b0);
		end
	endtask : wait_idle
endmodule : cdid_host
`default_nettype wire

// ---- cdid_ram.sv ----
// holds the shared constants package and the flip-flop character memory
// assumes one clock domain and a single writer per memory instance

`timescale 1ns/1ps
`default_nettype none

package cdid_pkg;
	// instruction groups, chosen by the highest set bit of the byte
	typedef enum logic [3:0] {
		CDID_CMD_NONE  = 4'h0,
		CDID_CMD_CLEAR = 4'h1,
		CDID_CMD_HOME  = 4'h2,
		CDID_CMD_ENTRY = 4'h3,
		CDID_CMD_DISP  = 4'h4,
		CDID_CMD_SHIFT = 4'h5,
		CDID_CMD_FUNC  = 4'h6,
		CDID_CMD_GLYPH = 4'h7,
		CDID_CMD_DADDR = 4'h8
	} cdid_cmd_t;

	typedef enum logic [1:0] {
		CDID_ST_IDLE  = 2'h0,
		CDID_ST_EXEC  = 2'h1,
		CDID_ST_CLEAR = 2'h3
	} cdid_state_t;

	// host port addresses
	localparam logic [1:0] ADDR_INSTR    = 2'h0;
	localparam logic [1:0] ADDR_DATA     = 2'h1;
	localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
	localparam logic [1:0] ADDR_IRQ_EN   = 2'h3;

	// interrupt status bit positions
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_REJECT = 1;
	localparam int IRQ_CLEAR  = 2;
	localparam int IRQ_W      = 3;

	// instruction field positions
	localparam int F_ID     = 1;
	localparam int F_SH     = 0;
	localparam int F_DISP   = 2;
	localparam int F_CUR    = 1;
	localparam int F_BLINK  = 0;
	localparam int F_SC     = 3;
	localparam int F_RL     = 2;
	localparam int F_GMODE  = 3;
	localparam int F_PWR    = 2;
	localparam int F_DL     = 4;
	localparam int F_LINES  = 3;
	localparam int F_FSIZE  = 2;
	localparam int F_BUSY   = 7;

	localparam int DISP_DEPTH  = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam int AC_W        = 7;
	localparam int GLYPH_AW    = 6;
	localparam int CNT_W       = 17;

	// timing: clear figure given at the reference oscillator, converted straight to core_clk cycles; REF_OSC_KHZ is not used
	localparam int CLK_FREQ_KHZ   = 10000;
	localparam int REF_OSC_KHZ    = 250;
	localparam int CLEAR_TIME_US  = 6200;
	localparam int CLEAR_CYCLES   = CLEAR_TIME_US * CLK_FREQ_KHZ / 1000;
	localparam int CMD_EXEC_CYCLES = 2;

	// reset values and the clear fill character
	localparam logic [7:0]      BLANK_CHAR   = 8'h20;
	localparam logic            RST_ID       = 1'b1;
	localparam logic            RST_DL       = 1'b1;
	localparam logic [1:0]      RST_FT       = 2'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_EN  = 3'h0;
endpackage : cdid_pkg

module cdid_ram #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic          core_clk,  // core clock
	input  wire logic          rst_n,     // async reset, low
	input  wire logic          wr_en,     // write this cycle
	input  wire logic [AW-1:0] wr_addr,   // write index
	input  wire logic [7:0]    wr_data,   // write byte
	input  wire logic [AW-1:0] rd_addr,   // read index
	output logic      [7:0]    rd_data    // byte at rd_addr
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
	} cdid_ram_state_t;

	cdid_ram_state_t mem_reg;
	cdid_ram_state_t mem_next;

	always_comb begin
		mem_next = mem_reg;
		if (wr_en) begin
			mem_next.mem[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_reg <= '0;
		end else begin
			mem_reg <= mem_next;
		end
	end

	assign rd_data = mem_reg.mem[rd_addr];
endmodule : cdid_ram

`default_nettype wire

// ---- char_display_instruction_decoder_test.sv ----
// self-checking bench for the instruction decoder
// assumes the host model drives the port and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module char_display_instruction_decoder_test;
	localparam int CLR = 200;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] host_addr;
	logic [7:0] host_wdata, host_rdata, v;
	logic host_wr, host_rd, irq, busy_flag, display_on, cursor_on, blink_on;
	logic graphic_mode, power_on, bus_width_select, line_count, glyph_size;
	logic [6:0] address_counter, shift_offset;
	logic [1:0] font_table_select;
	int n_fail = 0;
	int n_checks = 0;
	always #50 core_clk = ~core_clk;
	cdid_decoder #(.CLEAR_CYCLES(CLR)) uut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .irq(irq),
		.busy_flag(busy_flag), .address_counter(address_counter), .shift_offset(shift_offset),
		.display_on(display_on), .cursor_on(cursor_on), .blink_on(blink_on), .graphic_mode(graphic_mode),
		.power_on(power_on), .bus_width_select(bus_width_select), .line_count(line_count),
		.glyph_size(glyph_size), .font_table_select(font_table_select));
	cdid_host host (.core_clk(core_clk), .host_rdata(host_rdata), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic cmd(input logic [7:0] d);
		logic ok;
		host.wr(cdid_pkg::ADDR_INSTR, d);
		host.wait_idle(ok);
		chk({7'h00, ok}, 8'h01);
	endtask : cmd
	task automatic dwr(input logic [7:0] d);
		logic ok;
		host.wr(cdid_pkg::ADDR_DATA, d);
		host.wait_idle(ok);
	endtask : dwr
	task automatic drd(input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		host.rd(cdid_pkg::ADDR_DATA, d);
		chk(d, exp);
		host.wait_idle(ok);
	endtask : drd
	function automatic logic [7:0] flags();
		return {display_on, cursor_on, blink_on, graphic_mode, power_on, bus_width_select, line_count, glyph_size};
	endfunction : flags
	task automatic t_reset;
		chk(flags(), 8'h04);
		chk({1'b0, address_counter}, 8'h00);
		chk({4'h0, irq, busy_flag, font_table_select}, 8'h00);
	endtask : t_reset
	task automatic t_addr;
		cmd(8'hC5);
		host.rd(cdid_pkg::ADDR_INSTR, v);
		chk(v, 8'h45);
		cmd(8'h7F);
		chk({1'b0, address_counter}, 8'h3F);
	endtask : t_addr
	task automatic t_data;
		cmd(8'h90);
		dwr(8'hA5);
		dwr(8'h5A);
		chk({1'b0, address_counter}, 8'h12);
		cmd(8'h90);
		drd(8'hA5);
		drd(8'h5A);
		cmd(8'h04);
		cmd(8'hA0);
		dwr(8'h33);
		chk({1'b0, address_counter}, 8'h1F);
		drd(8'h00);
		chk({1'b0, address_counter}, 8'h1E);
		cmd(8'hA0);
		drd(8'h33);
	endtask : t_data
	task automatic t_glyph;
		cmd(8'h06);
		cmd(8'h45);
		dwr(8'h1F);
		cmd(8'h45);
		drd(8'h1F);
		cmd(8'h85);
		drd(8'h00);
	endtask : t_glyph
	task automatic t_flags;
		cmd(8'h0F);
		cmd(8'h3E);
		cmd(8'h17);
		chk({7'h00, power_on}, 8'h01);
		cmd(8'h1B);
		chk(flags(), 8'hF7);
		chk({6'h00, font_table_select}, 8'h02);
		host.wr(cdid_pkg::ADDR_INSTR, 8'h00);
		@(posedge core_clk);
		#1 chk({7'h00, busy_flag}, 8'h00);
		cmd(8'h28);
		cmd(8'h08);
		cmd(8'h13);
		chk(flags(), 8'h02);
		chk({6'h00, font_table_select}, 8'h00);
	endtask : t_flags
	task automatic t_shift;
		cmd(8'h07);
		cmd(8'h80);
		dwr(8'h41);
		chk({1'b0, shift_offset}, 8'h01);
		cmd(8'h1C);
		chk({1'b0, shift_offset}, 8'h02);
		chk({1'b0, address_counter}, 8'h01);
		cmd(8'h1D);
		chk({shift_offset, 1'b0}, 8'h04);
		chk({1'b0, address_counter}, 8'h01);
		cmd(8'h10);
		chk({1'b0, address_counter}, 8'h00);
		cmd(8'h14);
		cmd(8'h06);
		dwr(8'h42);
		chk({1'b0, shift_offset}, 8'h02);
		cmd(8'h03);
		chk({1'b0, shift_offset}, 8'h00);
		drd(8'h41);
		drd(8'h42);
	endtask : t_shift
	task automatic t_clear;
		logic ok;
		cmd(8'h90);
		dwr(8'h77);
		host.wr(cdid_pkg::ADDR_IRQ_EN, 8'h07);
		host.wr(cdid_pkg::ADDR_IRQ_STAT, 8'h07);
		host.wr(cdid_pkg::ADDR_INSTR, 8'h01);
		host.rd(cdid_pkg::ADDR_DATA, v);
		chk(v, 8'h00);
		host.wr(cdid_pkg::ADDR_INSTR, 8'h0F);
		host.wait_idle(ok);
		chk({display_on, address_counter}, 8'h00);
		host.rd(cdid_pkg::ADDR_IRQ_STAT, v);
		chk({irq, v[6:0]}, 8'h87);
		host.wr(cdid_pkg::ADDR_IRQ_STAT, 8'h07);
		host.rd(cdid_pkg::ADDR_IRQ_STAT, v);
		chk({irq, v[6:0]}, 8'h00);
		host.wr(cdid_pkg::ADDR_IRQ_EN, 8'h00);
		cmd(8'h90);
		host.rd(cdid_pkg::ADDR_IRQ_STAT, v);
		chk({irq, v[6:0]}, 8'h01);
		drd(8'h20);
	endtask : t_clear
	initial begin
		#2_000_000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1 t_reset();
		t_addr();
		t_data();
		t_glyph();
		t_flags();
		t_shift();
		t_clear();
		finish_test();
	end
endmodule : char_display_instruction_decoder_test
`default_nettype wire
